// ===== tpfcs_consts.vh
// constants for the timer pin function and count source select block
// assumes 32-bit apb data, one aligned word per register
`ifndef TPFCS_CONSTS_VH
`define TPFCS_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define TPFCS_OFS_OUTDIS   12'h000
`define TPFCS_OFS_FUNC     12'h004
`define TPFCS_OFS_PWMSEL   12'h008
`define TPFCS_OFS_IOAB     12'h00C
`define TPFCS_OFS_IOCD     12'h010
`define TPFCS_OFS_CUTOFF   12'h014
`define TPFCS_OFS_EXTINT   12'h018
`define TPFCS_OFS_PORTDIR  12'h01C
`define TPFCS_OFS_CHCTL0   12'h020
`define TPFCS_OFS_CHCTL1   12'h024
`define TPFCS_OFS_OSC      12'h028
`define TPFCS_OFS_STATUS   12'h02C

// ****************************************
// field positions
// ****************************************
`define TPFCS_FUNC_CMD_LSB    0
`define TPFCS_FUNC_FIXPWM     2
`define TPFCS_FUNC_EXTCLK     3
`define TPFCS_INT_POL         0
`define TPFCS_INT_EN          1
`define TPFCS_CH_SRC_LSB      0
`define TPFCS_CH_EDGE_LSB     3
`define TPFCS_IO_LO_LSB       0
`define TPFCS_IO_HI_LSB       4

// ****************************************
// reset values
// ****************************************
`define TPFCS_RST_OUTDIS   4'hF
`define TPFCS_RST_FUNC     4'h4
`define TPFCS_RST_BYTE     8'h00

// ****************************************
// pin function codes
// ****************************************
`define TPFCS_PF_PORT      3'h0
`define TPFCS_PF_COMPL     3'h1
`define TPFCS_PF_RSYNC     3'h2
`define TPFCS_PF_PWM       3'h3
`define TPFCS_PF_CMP       3'h4
`define TPFCS_PF_CAP       3'h5
`define TPFCS_PF_FIXPWM    3'h6

// ****************************************
// count source codes and edge codes
// ****************************************
`define TPFCS_SRC_DIV1     3'h0
`define TPFCS_SRC_DIV2     3'h1
`define TPFCS_SRC_DIV4     3'h2
`define TPFCS_SRC_DIV8     3'h3
`define TPFCS_SRC_DIV32    3'h4
`define TPFCS_SRC_EXT      3'h5
`define TPFCS_SRC_OSC      3'h6
`define TPFCS_EDGE_RISE    2'h0
`define TPFCS_EDGE_FALL    2'h1

`endif

// ===== tpfcs_timer_pin_select.v
// pin function selection for channel 1 and count source selection for both channels of a two-channel timer
// assumes an apb master on pclk, pin levels arriving asynchronously
// How it works
// RL1 - output enabled and combination 1X: pin carries complementary pwm
// RL2 - output enabled and combination 01: pin carries reset synchronous pwm
// RL3 - enabled, fixed bit 1, combination 00, pwm select 1: plain pwm
// RL4 - same but pwm select 0 and io 001 or 01X: compare output
// RL5 - fixed bit 1, combination 00, select 0, io 1XX: capture input
// RL6 - software keeps a capture pin's direction bit at input
// RL7 - cutoff input only with enable 1, polarity 0, int enable 1, dir 0
// RL8 - otherwise the cutoff pin is general port or interrupt input
// RL9 - source selection same in all modes, no external clock in fixed pwm; here ext_ok accepts the external clock only with the fixed pwm bit set
// RL10 - source field selects clock divided by 1, 2, 4, 8 or 32
// RL11 - software enables the fast oscillator and writes code 110
// RL12 - software enables external clock and writes code 101
// RL13 - external source counts on the edge chosen by edge select
// RL14 - software keeps the external clock pin as input
// RL15 - software turns the oscillator on before selecting it
// RL16 - unmatched combinations release the pin to port logic
`timescale 1ns/1ps
`default_nettype none
`include "tpfcs_consts.vh"

module tpfcs_timer_pin_select
(
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  input  wire [3:0]   compl_wave,
  input  wire [3:0]   rsync_wave,
  input  wire [3:0]   pwm_wave,
  input  wire [3:0]   cmp_wave,
  input  wire [3:0]   port_out,
  input  wire [3:0]   port_oe,
  input  wire [3:0]   channel1_pin_in,
  output reg  [3:0]   channel1_pin_out,
  output reg  [3:0]   channel1_pin_oe,
  output reg  [3:0]   capture_trig,
  input  wire         cutoff_interrupt_pin,
  output reg          cutoff_req,
  output reg          ext_int_in,
  input  wire         fast_onchip_osc_clock,
  input  wire         ext_count_clock_pin,
  output reg  [1:0]   count_tick
);

  // ****************************************
  // register file
  // ****************************************
  reg [3:0] pin_output_disable_reg_q;
  reg [3:0] function_control_reg_q;
  reg [3:0] pwm_mode_select_reg_q;
  reg [7:0] io_control_ab_reg_q;
  reg [7:0] io_control_cd_reg_q;
  reg       cutoff_input_enable_q;
  reg [1:0] ext_interrupt_enable_reg_q;
  reg       cutoff_pin_direction_q;
  reg [7:0] timer_port_direction_reg_q;
  reg [4:0] channel_control_reg_q [0:1];
  reg       fast_osc_enable_q;

  wire       wr_en = psel & penable & pwrite;
  wire [1:0] combination_mode_field = function_control_reg_q[`TPFCS_FUNC_CMD_LSB+1:`TPFCS_FUNC_CMD_LSB];
  wire       fixed_period_pwm_select = function_control_reg_q[`TPFCS_FUNC_FIXPWM];
  wire       ext_clock_enable = function_control_reg_q[`TPFCS_FUNC_EXTCLK];

  // always ready; any unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);

  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a[1:0] == 2'h0) && (a <= `TPFCS_OFS_STATUS);
    end
  endfunction

  // software writes, taken in the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_output_disable_reg_q   <= `TPFCS_RST_OUTDIS;
      function_control_reg_q     <= `TPFCS_RST_FUNC;
      pwm_mode_select_reg_q      <= 4'h0;
      io_control_ab_reg_q        <= `TPFCS_RST_BYTE;
      io_control_cd_reg_q        <= `TPFCS_RST_BYTE;
      cutoff_input_enable_q      <= 1'b0;
      ext_interrupt_enable_reg_q <= 2'h0;
      cutoff_pin_direction_q     <= 1'b0;
      timer_port_direction_reg_q <= `TPFCS_RST_BYTE;
      channel_control_reg_q[0]   <= 5'h00;
      channel_control_reg_q[1]   <= 5'h00;
      fast_osc_enable_q          <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TPFCS_OFS_OUTDIS:  pin_output_disable_reg_q   <= pwdata[3:0];
        `TPFCS_OFS_FUNC:    function_control_reg_q     <= pwdata[3:0];
        `TPFCS_OFS_PWMSEL:  pwm_mode_select_reg_q      <= pwdata[3:0];
        `TPFCS_OFS_IOAB:    io_control_ab_reg_q        <= pwdata[7:0];
        `TPFCS_OFS_IOCD:    io_control_cd_reg_q        <= pwdata[7:0];
        `TPFCS_OFS_CUTOFF:  cutoff_input_enable_q      <= pwdata[0];
        `TPFCS_OFS_EXTINT:  ext_interrupt_enable_reg_q <= pwdata[1:0];
        `TPFCS_OFS_PORTDIR:
        begin
          timer_port_direction_reg_q <= pwdata[7:0];
          cutoff_pin_direction_q     <= pwdata[8];
        end
        `TPFCS_OFS_CHCTL0:  channel_control_reg_q[0]   <= pwdata[4:0];
        `TPFCS_OFS_CHCTL1:  channel_control_reg_q[1]   <= pwdata[4:0];
        `TPFCS_OFS_OSC:     fast_osc_enable_q          <= pwdata[0];
        default:            fast_osc_enable_q          <= fast_osc_enable_q;
      endcase
    end
  end

  // ****************************************
  // pin function decode
  // ****************************************
  // each pin's io control nibble; pin a has no pwm select, read as zero
  function [2:0] pin_func;
    input       dis;
    input [1:0] cmd;
    input       fix;
    input       pwm_sel;
    input [2:0] io;
    begin
      if (!dis && cmd[1])
        pin_func = `TPFCS_PF_COMPL;                            // [RL1]
      else if (!dis && cmd == 2'h1)
        pin_func = `TPFCS_PF_RSYNC;                            // [RL2]
      // channel 1 pins carry no fixed period waveform; with the bit clear they stay port
      else if (cmd != 2'h0 || !fix)
        pin_func = `TPFCS_PF_PORT;                             // [RL16]
      else if (!dis && pwm_sel)
        pin_func = `TPFCS_PF_PWM;                              // [RL3]
      else if (!pwm_sel && io[2])
        pin_func = `TPFCS_PF_CAP;                              // [RL5]
      else if (!dis && !pwm_sel && (io == 3'h1 || io[2:1] == 2'h1))
        pin_func = `TPFCS_PF_CMP;                              // [RL4]
      else
        pin_func = `TPFCS_PF_PORT;                             // [RL16]
    end
  endfunction

  // three-stage input synchronisers; first stage feeds the second only
  reg [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_v_q;
  reg [2:0] cut_s_q, ext_s_q;
  reg       cut_v_q, ext_v_q, ext_prev_q;
  reg [2:0] func_q [0:3];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q   <= 4'h0;
      pin_s2_q   <= 4'h0;
      pin_s3_q   <= 4'h0;
      pin_v_q    <= 4'h0;
      cut_s_q    <= 3'h7;
      ext_s_q    <= 3'h0;
      cut_v_q    <= 1'b1;
      ext_v_q    <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q   <= channel1_pin_in;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_v_q    <= (pin_s2_q & pin_s3_q) | (pin_v_q & (pin_s2_q | pin_s3_q));
      cut_s_q    <= {cut_s_q[1:0], cutoff_interrupt_pin};
      ext_s_q    <= {ext_s_q[1:0], ext_count_clock_pin};
      if (cut_s_q[1] == cut_s_q[2])
        cut_v_q <= cut_s_q[1];
      if (ext_s_q[1] == ext_s_q[2])
        ext_v_q <= ext_s_q[1];
      ext_prev_q <= ext_v_q;
    end
  end

  // registered pin routing so the pin data comes from flip-flops
  integer k;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel1_pin_out <= 4'h0;
      channel1_pin_oe  <= 4'h0;
      capture_trig     <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
        func_q[k] <= `TPFCS_PF_PORT;
    end
    else
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        func_q[k] <= pin_func(pin_output_disable_reg_q[k], combination_mode_field, fixed_period_pwm_select,
                              (k == 0) ? 1'b0 : pwm_mode_select_reg_q[k],
                              (k == 0) ? io_control_ab_reg_q[2:0] :
                              (k == 1) ? io_control_ab_reg_q[6:4] :
                              (k == 2) ? io_control_cd_reg_q[2:0] : io_control_cd_reg_q[6:4]);
        case (func_q[k])
          `TPFCS_PF_COMPL:  channel1_pin_out[k] <= compl_wave[k];
          `TPFCS_PF_RSYNC:  channel1_pin_out[k] <= rsync_wave[k];
          `TPFCS_PF_PWM:    channel1_pin_out[k] <= pwm_wave[k];
          `TPFCS_PF_CMP:    channel1_pin_out[k] <= cmp_wave[k];
          default:          channel1_pin_out[k] <= port_out[k];
        endcase
        // capture pins and port pins follow port direction; the rest drive
        channel1_pin_oe[k] <= (func_q[k] == `TPFCS_PF_PORT || func_q[k] == `TPFCS_PF_CAP) ?
                              port_oe[k] : 1'b1;
        capture_trig[k]    <= (func_q[k] == `TPFCS_PF_CAP) & pin_v_q[k]; // [RL5] [RL6]
      end
    end
  end

  // ****************************************
  // cutoff pin
  // ****************************************
  wire cutoff_sel = cutoff_input_enable_q & ~ext_interrupt_enable_reg_q[`TPFCS_INT_POL] &
                    ext_interrupt_enable_reg_q[`TPFCS_INT_EN] & ~cutoff_pin_direction_q;

  // low level on the pin requests cutoff only in cutoff mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cutoff_req <= 1'b0;
      ext_int_in <= 1'b1;
    end
    else
    begin
      cutoff_req <= cutoff_sel & ~cut_v_q;                       // [RL7]
      ext_int_in <= cut_v_q;                                     // [RL8]
    end
  end

  // ****************************************
  // count source select
  // ****************************************
  reg [4:0] div_q;
  reg [2:0] osc_s_q;
  reg [1:0] osc_prev_q;
  reg       osc_v_q;

  // osc edges counted in pclk domain; each osc phase must last two pclk cycles to be seen
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q      <= 5'h00;
      osc_s_q    <= 3'h0;
      osc_prev_q <= 2'h0;
      osc_v_q    <= 1'b0;
    end
    else
    begin
      div_q      <= div_q + 5'h01;
      osc_s_q    <= {osc_s_q[1:0], fast_onchip_osc_clock};
      if (osc_s_q[1] == osc_s_q[2])
        osc_v_q <= osc_s_q[1];
      osc_prev_q <= {osc_prev_q[0], osc_v_q};
    end
  end

  function src_tick;
    input [4:0] cfg;
    input [4:0] dv;
    input       ext_rise;
    input       ext_fall;
    input       osc_tick;
    input       ext_ok;
    input       osc_ok;
    begin
      case (cfg[`TPFCS_CH_SRC_LSB+2:`TPFCS_CH_SRC_LSB])
        `TPFCS_SRC_DIV1:  src_tick = 1'b1;                       // [RL10]
        `TPFCS_SRC_DIV2:  src_tick = (dv[0] == 1'b1);            // [RL10]
        `TPFCS_SRC_DIV4:  src_tick = (dv[1:0] == 2'h3);          // [RL10]
        `TPFCS_SRC_DIV8:  src_tick = (dv[2:0] == 3'h7);          // [RL10]
        `TPFCS_SRC_DIV32: src_tick = (dv == 5'h1F);              // [RL10]
        `TPFCS_SRC_EXT:   src_tick = ext_ok & (cfg[4:3] == `TPFCS_EDGE_RISE ? ext_rise :
                                               cfg[4:3] == `TPFCS_EDGE_FALL ? ext_fall :
                                               (ext_rise | ext_fall)); // [RL13] [RL12]
        `TPFCS_SRC_OSC:   src_tick = osc_ok & osc_tick;          // [RL11] [RL15]
        default:          src_tick = 1'b0;
      endcase
    end
  endfunction

  // external clock accepted only while the fixed period pwm bit is set
  wire ext_ok   = ext_clock_enable & fixed_period_pwm_select & ~timer_port_direction_reg_q[0]; // [RL9] [RL14]
  wire ext_rise = ext_v_q & ~ext_prev_q;
  wire ext_fall = ~ext_v_q & ext_prev_q;
  wire osc_tick = osc_prev_q[0] & ~osc_prev_q[1];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_tick <= 2'h0;
    else
    begin
      count_tick[0] <= src_tick(channel_control_reg_q[0], div_q, ext_rise, ext_fall, osc_tick, ext_ok,
                                fast_osc_enable_q);
      count_tick[1] <= src_tick(channel_control_reg_q[1], div_q, ext_rise, ext_fall, osc_tick, ext_ok,
                                fast_osc_enable_q);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // read data captured in the setup cycle, so it stands from a flip-flop through the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable)
    begin
      case (paddr)
        `TPFCS_OFS_OUTDIS:  prdata <= {28'h0, pin_output_disable_reg_q};
        `TPFCS_OFS_FUNC:    prdata <= {28'h0, function_control_reg_q};
        `TPFCS_OFS_PWMSEL:  prdata <= {28'h0, pwm_mode_select_reg_q};
        `TPFCS_OFS_IOAB:    prdata <= {24'h0, io_control_ab_reg_q};
        `TPFCS_OFS_IOCD:    prdata <= {24'h0, io_control_cd_reg_q};
        `TPFCS_OFS_CUTOFF:  prdata <= {31'h0, cutoff_input_enable_q};
        `TPFCS_OFS_EXTINT:  prdata <= {30'h0, ext_interrupt_enable_reg_q};
        `TPFCS_OFS_PORTDIR: prdata <= {23'h0, cutoff_pin_direction_q, timer_port_direction_reg_q};
        `TPFCS_OFS_CHCTL0:  prdata <= {27'h0, channel_control_reg_q[0]};
        `TPFCS_OFS_CHCTL1:  prdata <= {27'h0, channel_control_reg_q[1]};
        `TPFCS_OFS_OSC:     prdata <= {31'h0, fast_osc_enable_q};
        `TPFCS_OFS_STATUS:  prdata <= {19'h0, cutoff_sel, func_q[3], func_q[2], func_q[1], func_q[0]};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tpfcs_pins_model.sv
// far-side pin model: trigger sources, cutoff line, external and oscillator clocks
// assumes the bench steers levels and gates the external clock
`timescale 1ns/1ps
`default_nettype none
module tpfcs_pins_model
(
  input  wire logic       clk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] trig_lvl,
  input  wire logic       cut_lvl,
  input  wire logic       ext_run,
  output logic [3:0]      pin_in,
  output logic            cut_pin,
  output logic            ext_clk,
  output var logic        osc_clk
);
  logic [1:0] div_q;
  // ****************************************
  // wire levels and clocks
  // ****************************************
  // a capture pin is only driven from outside while the block leaves it as input
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & trig_lvl);
  assign cut_pin = cut_lvl;
  // stand-in oscillator, unrelated to pclk; slow enough that the three-flop filter follows each phase
  initial
  begin
    osc_clk = 1'b0;
    forever #37 osc_clk = ~osc_clk;
  end
  // pulses last four cycles, so the input filter always sees them; still when idle
  initial ext_clk = 1'b0;
  initial div_q = 2'h0;
  always @(posedge clk)
    if (ext_run)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
        ext_clk <= ~ext_clk;
    end
endmodule
`default_nettype wire

// ===== tpfcs_timer_pin_select_chk.sv
// port-level checker for the timer pin select block
// assumes apb on pclk; bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module tpfcs_timer_pin_select_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  channel1_pin_oe,
  input wire logic [3:0]  capture_trig,
  input wire logic        cutoff_req,
  input wire logic        ext_int_in
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  AST_RDY: assert property (s_acc |-> pready) else $error("no ready in access");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("error outside access");
  AST_ERR_MAP: assert property (s_acc ##0 (paddr > 12'h02C || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped not refused");
  AST_ERR_OK: assert property (s_acc ##0 (paddr <= 12'h02C && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped refused");
  AST_RD_ERR: assert property (s_rd ##0 pslverr |-> prdata == 32'h0) else $error("refused read not 0");
  AST_RD_DIS: assert property (s_rd ##0 paddr == 12'h000 |-> prdata[31:4] == 28'h0)
    else $error("unused bits set");
  AST_CAP_IN: assert property ((capture_trig & channel1_pin_oe) == 4'h0)
    else $error("capture pin driven");
  // ext_int_in and the request are registered on the same edge from one filtered level
  AST_CUT_LOW: assert property (cutoff_req |-> !ext_int_in || $past(ext_int_in) == 1'b0)
    else $error("cutoff with pin high");
  AST_CUT_END: assert property ($rose(ext_int_in) |-> ##[0:3] !cutoff_req)
    else $error("cutoff held after pin high");
endmodule
bind tpfcs_timer_pin_select tpfcs_timer_pin_select_chk chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .channel1_pin_oe, .capture_trig, .cutoff_req, .ext_int_in);
`default_nettype wire

// ===== tpfcs_timer_pin_select_tb.sv
// self-checking bench for the timer pin select block
// assumes the pin model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "tpfcs_consts.vh"
module tpfcs_timer_pin_select_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        cutoff_req, ext_int_in, cutoff_interrupt_pin, cut_lvl, ext_run;
  logic        fast_onchip_osc_clock, ext_count_clock_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  compl_wave, rsync_wave, pwm_wave, cmp_wave, port_out, port_oe, capm;
  logic [11:0] st;
  logic        fx;
  logic [3:0]  channel1_pin_in, channel1_pin_out, channel1_pin_oe, capture_trig, trig_lvl;
  logic [1:0]  count_tick, edg;
  logic [2:0]  code;
  logic [20:0] cfg;
  logic [15:0] seed;
  int          n_mismatch, cmp_count, cyc, i, n, e;
  // ****************************************
  // instances, clock, timeout
  // ****************************************
  tpfcs_timer_pin_select tpfcs_timer_pin_select_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .compl_wave, .rsync_wave, .pwm_wave, .cmp_wave,
    .port_out, .port_oe, .channel1_pin_in, .channel1_pin_out, .channel1_pin_oe, .capture_trig,
    .cutoff_interrupt_pin, .cutoff_req, .ext_int_in, .fast_onchip_osc_clock, .ext_count_clock_pin, .count_tick);
  tpfcs_pins_model tpfcs_pins_model_inst (.clk(pclk), .pin_out(channel1_pin_out), .pin_oe(channel1_pin_oe),
    .trig_lvl(trig_lvl), .cut_lvl(cut_lvl), .ext_run(ext_run), .pin_in(channel1_pin_in),
    .cut_pin(cutoff_interrupt_pin), .ext_clk(ext_count_clock_pin), .osc_clk(fast_onchip_osc_clock));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  function logic [15:0] lfsr(input logic [15:0] x);
    for (int k = 0; k < 16; k++) x = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    return x;
  endfunction
  // expected pin function from disable, combination, fixed-period bit, pwm select and io field
  function logic [2:0] exp_pf(input logic dis, input logic [1:0] cmd, input logic fix, input logic ps,
                              input logic [2:0] io);
    if (!dis && cmd[1]) return `TPFCS_PF_COMPL;
    if (!dis && cmd == 2'h1) return `TPFCS_PF_RSYNC;
    if (cmd != 2'h0 || !fix) return `TPFCS_PF_PORT;
    if (ps) return dis ? `TPFCS_PF_PORT : `TPFCS_PF_PWM;
    if (io[2]) return `TPFCS_PF_CAP;
    return (!dis && io != 3'h0) ? `TPFCS_PF_CMP : `TPFCS_PF_PORT;
  endfunction
  function logic [1:0] exp_pin(input logic [2:0] f, input int p);
    case (f)
      `TPFCS_PF_COMPL: return {1'b1, compl_wave[p]};
      `TPFCS_PF_RSYNC: return {1'b1, rsync_wave[p]};
      `TPFCS_PF_PWM:   return {1'b1, pwm_wave[p]};
      `TPFCS_PF_CMP:   return {1'b1, cmp_wave[p]};
      default:         return {port_oe[p], port_out[p]};
    endcase
  endfunction
  // ticks in 64 cycles; -1 means any nonzero count
  function int exp_cnt(input logic [2:0] c, input logic [1:0] g);
    case (c)
      3'h0: return 64;
      3'h1: return 32;
      3'h2: return 16;
      3'h3: return 8;
      3'h4: return 2;
      3'h5: return g == 2'h2 ? 16 : 8;
      3'h6: return -1;
      default: return 0;
    endcase
  endfunction
  task chk(input logic ok, input string m);
    cmp_count++;
    if (!ok)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // one apb transfer, request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, compl_wave, rsync_wave, pwm_wave, cmp_wave} = '0;
    {port_out, port_oe, trig_lvl, ext_run, presetn, n_mismatch, cmp_count, cyc} = '0;
    cut_lvl = 1'b1;
    seed = 16'h0024;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `TPFCS_OFS_OUTDIS, 0);
    chk(rdat === 32'h0000000F, "disable reset value");
    apb(0, `TPFCS_OFS_FUNC, 0);
    chk(rdat === 32'h00000004, "function reset value");
    apb(1, 12'h030, 32'hFFFFFFFF);
    chk(rerr === 1'b1, "unmapped write accepted");
    apb(0, 12'h030, 0);
    chk(rerr === 1'b1 && rdat === 32'h0, "unmapped read");
    apb(1, `TPFCS_OFS_PORTDIR, 0);
    // corner settings first, then random ones
    for (int t = 0; t < 44; t++)
    begin
      seed = lfsr(seed);
      cfg[15:0] = seed;
      seed = lfsr(seed);
      cfg[20:16] = seed[4:0];
      if (t < 4) cfg = t == 0 ? 21'h000020 : t == 1 ? 21'h00001A : t == 2 ? 21'h12480F : 21'h0D4240;
      seed = lfsr(seed);
      {compl_wave, rsync_wave, pwm_wave, cmp_wave} <= seed;
      seed = lfsr(seed);
      {port_out, trig_lvl} <= {seed[11:8], seed[3:0]};
      port_oe <= 4'h0;
      fx = t < 4 || seed[15];
      apb(1, `TPFCS_OFS_OUTDIS, cfg[3:0]);
      apb(1, `TPFCS_OFS_FUNC, {1'b0, fx, cfg[5:4]});
      apb(1, `TPFCS_OFS_PWMSEL, {cfg[8:6], 1'b0});
      apb(1, `TPFCS_OFS_IOAB, {cfg[14:12], 1'b0, cfg[11:9]});
      apb(1, `TPFCS_OFS_IOCD, {cfg[20:18], 1'b0, cfg[17:15]});
      // software keeps capture pins as inputs; the rest get a direction once the setting has settled
      for (int p = 0; p < 4; p++)
      begin
        st[3 * p +: 3] = exp_pf(cfg[p], cfg[5:4], fx, p == 0 ? 1'b0 : cfg[5 + p], cfg[9 + 3 * p +: 3]);
        capm[p] = st[3 * p +: 3] == `TPFCS_PF_CAP;
      end
      repeat (3) @(posedge pclk);
      port_oe <= seed[7:4] & ~capm;
      repeat (10) @(posedge pclk);
      #1;
      for (int p = 0; p < 4; p++)
      begin
        code = st[3 * p +: 3];
        if (code == `TPFCS_PF_CAP)
          chk(channel1_pin_oe[p] === 1'b0 && capture_trig[p] === trig_lvl[p], "capture pin");
        else
          chk({channel1_pin_oe[p], channel1_pin_out[p], capture_trig[p]} === {exp_pin(code, p), 1'b0}, "pin");
      end
      apb(0, `TPFCS_OFS_STATUS, 0);
      chk(rdat === {20'h0, st}, "status codes");
    end
    // every setting of the four cutoff controls, pin low then high
    for (i = 0; i < 16; i++)
    begin
      cut_lvl <= 1'b0;
      apb(1, `TPFCS_OFS_CUTOFF, i[0]);
      apb(1, `TPFCS_OFS_EXTINT, {i[2], i[1]});
      apb(1, `TPFCS_OFS_PORTDIR, {i[3], 8'h00});
      repeat (8) @(posedge pclk);
      #1;
      chk(cutoff_req === (i == 5) && ext_int_in === 1'b0, "cutoff on low pin");
      cut_lvl <= 1'b1;
      repeat (8) @(posedge pclk);
      #1;
      chk(cutoff_req === 1'b0 && ext_int_in === 1'b1, "cutoff after high pin");
    end
    apb(1, `TPFCS_OFS_PORTDIR, 0);
    apb(1, `TPFCS_OFS_FUNC, 32'h0000000C);
    apb(1, `TPFCS_OFS_OSC, 1);
    ext_run <= 1'b1;
    // all source codes on both channels, edge choices, then blocked sources
    for (i = 0; i < 20; i++)
    begin
      code = i < 16 ? i[3:1] : (i == 19 ? 3'h6 : 3'h5);
      edg = i == 16 ? 2'h1 : (i == 17 ? 2'h2 : 2'h0);
      if (i == 18) apb(1, `TPFCS_OFS_FUNC, 32'h00000008);
      if (i == 19) apb(1, `TPFCS_OFS_OSC, 0);
      apb(1, i[0] ? `TPFCS_OFS_CHCTL1 : `TPFCS_OFS_CHCTL0, {edg, code});
      repeat (8) @(posedge pclk);
      n = 0;
      repeat (64)
      begin
        @(posedge pclk);
        #1;
        n += count_tick[i[0]];
      end
      e = i > 17 ? 0 : exp_cnt(code, edg);
      chk(e < 0 ? n > 0 : (n >= e - 2 && n <= e + 2), "tick count");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
